// >>> tb/sac_alarm_checker.sv
// Port checker of the alarm block
`timescale 1ns/1ps
module sac_alarm_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic sample_valid,
  input wire logic [1:0] diagnostic_flags,
  input wire logic io_line_one,
  input wire logic io_line_one_oe,
  input wire logic io_line_two,
  input wire logic io_line_two_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic any_flag = |diagnostic_flags;
  sequence s_cs_idle;
    spi_cs_n [*8];
  endsequence
  property p_flag_hold;
    !sample_valid |=> $stable(diagnostic_flags);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flags moved without a sample");
  property p_reset;
    $fell(rst) |-> !any_flag && !io_line_one_oe && !io_line_two_oe;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not idle after reset");
  property p_one_line;
    !(io_line_one_oe && io_line_two_oe);
  endproperty
  a_one_line: assert property (p_one_line)
    else $error("both lines driven");
  property p_off1;
    !io_line_one_oe |-> !io_line_one;
  endproperty
  a_off1: assert property (p_off1)
    else $error("line one high while off");
  property p_off2;
    !io_line_two_oe |-> !io_line_two;
  endproperty
  a_off2: assert property (p_off2)
    else $error("line two high while off");
  property p_cfg_quiet;
    s_cs_idle |=> $stable({io_line_one_oe, io_line_two_oe});
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("enable moved without a write");
  property p_io1_cause;
    $changed(io_line_one) && $stable(io_line_one_oe)
      |-> $past(any_flag) != $past(any_flag, 2);
  endproperty
  a_io1_cause: assert property (p_io1_cause)
    else $error("line one moved without flag change");
  property p_io2_cause;
    $changed(io_line_two) && $stable(io_line_two_oe)
      |-> $past(any_flag) != $past(any_flag, 2);
  endproperty
  a_io2_cause: assert property (p_io2_cause)
    else $error("line two moved without flag change");
endmodule : sac_alarm_checker

bind sac_alarm_control sac_alarm_checker sac_alarm_checker_inst (
  .clk_sys, .rst, .spi_cs_n, .sample_valid, .diagnostic_flags,
  .io_line_one, .io_line_one_oe, .io_line_two, .io_line_two_oe);

// >>> tb/sac_host.sv
// Host model sending serial write frames
`timescale 1ns/1ps
module sac_host (
  input wire logic clk_sys,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_din
);
  initial begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_din = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_clk
  // Write flag, address, data byte, MSB first
  task automatic send(input logic [15:0] w);
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sclk = 1'b0;
      spi_din = w[i];
      wait_clk(8);
      spi_sclk = 1'b1;
      wait_clk(8);
    end
    wait_clk(10);
    spi_cs_n = 1'b1;
    spi_din = ~spi_din;
    wait_clk(10);
  endtask : send
endmodule : sac_host

// >>> tb/test_sac_alarm_control.sv
// Self-checking bench of the alarm block
`timescale 1ns/1ps
`include "sac_consts.svh"
module test_sac_alarm_control;
  import sac_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic spi_sclk, spi_cs_n, spi_din, io_line_one, io_line_one_oe;
  logic sample_valid = 1'b0;
  sac_sample_t sample = '0;
  logic [1:0] diagnostic_flags;
  logic io_line_two, io_line_two_oe;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  sac_host sac_host_inst (.clk_sys, .spi_sclk, .spi_cs_n, .spi_din);
  sac_alarm_control sac_alarm_control_inst (.clk_sys, .rst, .spi_sclk,
    .spi_cs_n, .spi_din, .sample_valid, .sample, .diagnostic_flags,
    .io_line_one, .io_line_one_oe, .io_line_two, .io_line_two_oe);
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors = errors + 1;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    sac_host_inst.send({1'b1, a, d});
  endtask : wr
  task automatic put(input int c, input logic [15:0] r, f);
    sample = '0;
    sample.raw[(6 - c) * 16 +: 16] = r;
    sample.filt[(6 - c) * 16 +: 16] = f;
    sample_valid = 1'b1;
    sac_host_inst.wait_clk(1);
    sample_valid = 1'b0;
    sac_host_inst.wait_clk(2);
  endtask : put
  function automatic logic [7:0] pins();
    return {4'h0, io_line_one, io_line_one_oe, io_line_two, io_line_two_oe};
  endfunction : pins
  task automatic t_reset();
    chk(pins(), 8'h00);
    put(1, 16'h7fff, 16'h7fff);
    chk({6'h00, diagnostic_flags}, 8'h00);
  endtask : t_reset
  task automatic t_static();
    int ax;
    logic [7:0] on;
    wr(`SAC_ADDR_THR1_LO, 8'h64);
    wr(`SAC_ADDR_THR2_LO, 8'h64);
    for (int c = 0; c < 8; c++) begin
      ax = (c % 7 == 0) ? 1 : c;
      on = (c % 7 == 0) ? 8'h00 : 8'h03;
      wr(`SAC_ADDR_CTRL_HI, {c[3:0], c[3:0]});
      wr(`SAC_ADDR_CTRL_LO, 8'h30);
      put(ax, 16'h00c8, 16'h00c8);
      chk({6'h00, diagnostic_flags}, on);
      put(ax, 16'hff38, 16'hff38);
      chk({6'h00, diagnostic_flags}, 8'h00);
      wr(`SAC_ADDR_CTRL_LO, 8'h00);
      put(ax, 16'hff38, 16'hff38);
      chk({6'h00, diagnostic_flags}, on);
      put(ax, 16'h00c8, 16'h00c8);
      chk({6'h00, diagnostic_flags}, 8'h00);
    end
  endtask : t_static
  task automatic t_filter();
    wr(`SAC_ADDR_CTRL_HI, 8'h11);
    wr(`SAC_ADDR_CTRL_LO, 8'h38);
    put(1, 16'h0032, 16'h00c8);
    chk({6'h00, diagnostic_flags}, 8'h03);
    wr(`SAC_ADDR_CTRL_LO, 8'h30);
    put(1, 16'h0032, 16'h00c8);
    chk({6'h00, diagnostic_flags}, 8'h00);
  endtask : t_filter
  task automatic t_ind();
    wr(`SAC_ADDR_CTRL_LO, 8'h37);
    put(1, 16'h00c8, 16'h00c8);
    chk(pins(), 8'h03);
    wr(`SAC_ADDR_CTRL_LO, 8'h34);
    chk(pins(), 8'h04);
    put(1, 16'h0032, 16'h0032);
    chk(pins(), 8'h0c);
    wr(`SAC_ADDR_CTRL_LO, 8'h30);
    chk(pins(), 8'h00);
  endtask : t_ind
  task automatic t_dyn();
    logic [15:0] v[8] = '{16'h64, 16'h69, 16'h78, 16'h78,
                          16'h78, 16'h78, 16'h7d, 16'h87};
    logic [7:0] e[8] = '{8'h0, 8'h0, 8'h1, 8'h0, 8'h1, 8'h0, 8'h0, 8'h1};
    wr(`SAC_ADDR_THR1_LO, 8'h0a);
    wr(`SAC_ADDR_SMPL1_LO, 8'h00);
    wr(`SAC_ADDR_CTRL_HI, 8'h01);
    wr(`SAC_ADDR_CTRL_LO, 8'h50);
    for (int i = 0; i < 8; i++) begin
      if (i == 4)
        wr(`SAC_ADDR_SMPL1_LO, 8'h03);
      put(1, v[i], v[i]);
      if (i > 0)
        chk({6'h00, diagnostic_flags}, e[i]);
    end
  endtask : t_dyn
  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    sac_host_inst.wait_clk(2);
    t_reset();
    t_static();
    t_filter();
    t_ind();
    t_dyn();
    summarize();
  end
endmodule : test_sac_alarm_control

// >>> verilog/sac_alarm_control.sv
// Alarm configuration, evaluation and indicator logic
`timescale 1ns/1ps
`include "sac_consts.svh"

module sac_alarm_control
  import sac_pkg::*;
#(
  parameter int HIST_DEPTH = 256
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_din,
  input wire logic sample_valid,
  input wire sac_sample_t sample,
  output logic [1:0] diagnostic_flags,
  output logic io_line_one,
  output logic io_line_one_oe,
  output logic io_line_two,
  output logic io_line_two_oe
);
  logic [2:0] sclk_sy, cs_sy, din_sy;
  logic sclk_st, cs_st, din_st, sclk_prev;
  logic next_sclk_st, next_cs_st, next_din_st;
  sac_spi_st_t st, next_st;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [15:0] shreg, next_shreg;
  logic [15:0] alarm_control, next_alarm_control;
  logic [15:0] alarm1_threshold, next_alarm1_threshold;
  logic [15:0] alarm2_threshold, next_alarm2_threshold;
  logic [7:0] alarm1_sample_count, next_alarm1_sample_count;
  logic [7:0] alarm2_sample_count, next_alarm2_sample_count;
  logic [1:0] next_flags;
  logic [15:0] hist [2][HIST_DEPTH];
  logic [7:0] wr_ptr, next_wr_ptr;
  logic [7:0] fill, next_fill;
  logic [15:0] cur [2];
  logic [15:0] old [2];
  logic [7:0] span [2];
  logic ind_level, next_one, next_two, next_one_oe, next_two_oe;

  function automatic logic [15:0] sel_value(input sac_axes_t a,
                                            input logic [3:0] code);
    case (code)
      4'h1: sel_value = a.x_rate;
      4'h2: sel_value = a.y_rate;
      4'h3: sel_value = a.z_rate;
      4'h4: sel_value = a.x_accel;
      4'h5: sel_value = a.y_accel;
      4'h6: sel_value = a.z_accel;
      default: sel_value = 16'h0000;
    endcase
  endfunction : sel_value

  function automatic logic src_on(input logic [3:0] code);
    src_on = (code != `SAC_SRC_OFF) && (code <= `SAC_SRC_MAX);
  endfunction : src_on

  function automatic logic [7:0] eff_count(input logic [7:0] n);
    eff_count = (n == 8'h00) ? 8'h01 : n;
  endfunction : eff_count

  function automatic logic compare(input logic [15:0] v,
                                   input logic [15:0] prev,
                                   input logic [15:0] thr,
                                   input logic dyn,
                                   input logic pol,
                                   input logic ready);
    logic [16:0] d;
    logic [16:0] mag;
    d = {v[15], v} - {prev[15], prev};
    mag = d[16] ? (17'h00000 - d) : d;
    if (dyn) begin
      compare = ready && (pol ? (mag > {1'b0, thr}) : (mag < {1'b0, thr}));
    end else begin
      compare = pol ? ($signed(v) > $signed(thr)) :
                      ($signed(v) < $signed(thr));
    end
  endfunction : compare

  // Pin synchroniser: value counts once stages two and three agree
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclk_sy <= 3'h7;
      cs_sy <= 3'h7;
      din_sy <= 3'h0;
    end else begin
      sclk_sy <= {sclk_sy[1:0], spi_sclk};
      cs_sy <= {cs_sy[1:0], spi_cs_n};
      din_sy <= {din_sy[1:0], spi_din};
    end
  end

  always_comb begin
    next_sclk_st = (sclk_sy[1] == sclk_sy[2]) ? sclk_sy[2] : sclk_st;
    next_cs_st = (cs_sy[1] == cs_sy[2]) ? cs_sy[2] : cs_st;
    next_din_st = (din_sy[1] == din_sy[2]) ? din_sy[2] : din_st;
  end

  // Serial frame receiver and register writes
  always_comb begin
    next_st = st;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_alarm_control = alarm_control;
    next_alarm1_threshold = alarm1_threshold;
    next_alarm2_threshold = alarm2_threshold;
    next_alarm1_sample_count = alarm1_sample_count;
    next_alarm2_sample_count = alarm2_sample_count;
    case (st)
      SAC_IDLE: begin
        next_bit_cnt = 5'h00;
        if (!cs_st) begin
          next_st = SAC_SHIFT;
        end
      end
      SAC_SHIFT: begin
        if (cs_st) begin
          next_st = SAC_IDLE;
        end else if (sclk_st && !sclk_prev) begin
          next_shreg = {shreg[14:0], din_st};
          next_bit_cnt = bit_cnt + 5'h01;
        end else if (bit_cnt == `SAC_FRAME_BITS) begin
          next_bit_cnt = 5'h00;
          if (shreg[`SAC_WR_BIT]) begin
            // Each frame carries one byte; high byte at odd address
            case (shreg[14:8])
              `SAC_ADDR_THR1_LO: next_alarm1_threshold[7:0] = shreg[7:0];
              `SAC_ADDR_THR1_HI: next_alarm1_threshold[15:8] = shreg[7:0];
              `SAC_ADDR_THR2_LO: next_alarm2_threshold[7:0] = shreg[7:0];
              `SAC_ADDR_THR2_HI: next_alarm2_threshold[15:8] = shreg[7:0];
              `SAC_ADDR_SMPL1_LO: next_alarm1_sample_count = shreg[7:0];
              `SAC_ADDR_SMPL2_LO: next_alarm2_sample_count = shreg[7:0];
              `SAC_ADDR_CTRL_LO: next_alarm_control[7:0] = shreg[7:0];
              `SAC_ADDR_CTRL_HI: next_alarm_control[15:8] = shreg[7:0];
              default: next_shreg = shreg;
            endcase
          end
        end
      end
      default: next_st = SAC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclk_st <= 1'b1;
      cs_st <= 1'b1;
      din_st <= 1'b0;
      sclk_prev <= 1'b1;
      st <= SAC_IDLE;
      bit_cnt <= 5'h00;
      shreg <= 16'h0000;
      alarm_control <= `SAC_RST_WORD;
      alarm1_threshold <= `SAC_RST_WORD;
      alarm2_threshold <= `SAC_RST_WORD;
      alarm1_sample_count <= 8'h00;
      alarm2_sample_count <= 8'h00;
    end else begin
      sclk_st <= next_sclk_st;
      cs_st <= next_cs_st;
      din_st <= next_din_st;
      sclk_prev <= sclk_st;
      st <= next_st;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      alarm_control <= next_alarm_control;
      alarm1_threshold <= next_alarm1_threshold;
      alarm2_threshold <= next_alarm2_threshold;
      alarm1_sample_count <= next_alarm1_sample_count;
      alarm2_sample_count <= next_alarm2_sample_count;
    end
  end

  // Alarm evaluation on each sensor sample
  always_comb begin
    // Filtered or raw data feeds both alarms
    cur[0] = sel_value(alarm_control[`SAC_BIT_FILT] ? sample.filt :
                       sample.raw, alarm_control[`SAC_SRC1_HI:`SAC_SRC1_LO]);
    cur[1] = sel_value(alarm_control[`SAC_BIT_FILT] ? sample.filt :
                       sample.raw, alarm_control[`SAC_SRC2_HI:`SAC_SRC2_LO]);
    span[0] = eff_count(alarm1_sample_count);
    span[1] = eff_count(alarm2_sample_count);
    old[0] = hist[0][8'(wr_ptr - span[0])];
    old[1] = hist[1][8'(wr_ptr - span[1])];
    next_wr_ptr = wr_ptr;
    next_fill = fill;
    next_flags = diagnostic_flags;
    if (sample_valid) begin
      next_wr_ptr = wr_ptr + 8'h01;
      next_fill = (fill == 8'hff) ? fill : fill + 8'h01;
      // Source code selects the axis or disables the alarm
      // Dynamic or static per alarm mode bit, above or below per alarm polarity
      next_flags[0] = src_on(alarm_control[`SAC_SRC1_HI:`SAC_SRC1_LO]) &&
        compare(cur[0], old[0], alarm1_threshold,
                alarm_control[`SAC_BIT_DYN1], alarm_control[`SAC_BIT_POL1],
                fill >= span[0]);
      next_flags[1] = src_on(alarm_control[`SAC_SRC2_HI:`SAC_SRC2_LO]) &&
        compare(cur[1], old[1], alarm2_threshold,
                alarm_control[`SAC_BIT_DYN2], alarm_control[`SAC_BIT_POL2],
                fill >= span[1]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sample_valid) begin
      hist[0][wr_ptr] <= cur[0];
      hist[1][wr_ptr] <= cur[1];
    end
  end

  // Indicator routing, enable and active level
  always_comb begin
    ind_level = alarm_control[`SAC_BIT_IND_POL] ? (|diagnostic_flags) :
                ~(|diagnostic_flags);
    next_one_oe = alarm_control[`SAC_BIT_IND_EN] &&
                  !alarm_control[`SAC_BIT_IND_SEL];
    next_two_oe = alarm_control[`SAC_BIT_IND_EN] &&
                  alarm_control[`SAC_BIT_IND_SEL];
    next_one = next_one_oe && ind_level;
    next_two = next_two_oe && ind_level;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr <= 8'h00;
      fill <= 8'h00;
      diagnostic_flags <= 2'h0;
      io_line_one <= 1'b0;
      io_line_one_oe <= 1'b0;
      io_line_two <= 1'b0;
      io_line_two_oe <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      fill <= next_fill;
      diagnostic_flags <= next_flags;
      io_line_one <= next_one;
      io_line_one_oe <= next_one_oe;
      io_line_two <= next_two;
      io_line_two_oe <= next_two_oe;
    end
  end
endmodule : sac_alarm_control

// >>> verilog/sac_consts.svh
// Register offsets, field positions and reset values of the alarm block
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
`define SAC_ADDR_THR1_LO 7'h40
`define SAC_ADDR_THR1_HI 7'h41
`define SAC_ADDR_THR2_LO 7'h42
`define SAC_ADDR_THR2_HI 7'h43
`define SAC_ADDR_SMPL1_LO 7'h44
`define SAC_ADDR_SMPL2_LO 7'h46
`define SAC_ADDR_CTRL_LO 7'h48
`define SAC_ADDR_CTRL_HI 7'h49
`define SAC_RST_WORD 16'h0000
`define SAC_BIT_DYN2 7
`define SAC_BIT_DYN1 6
`define SAC_BIT_POL2 5
`define SAC_BIT_POL1 4
`define SAC_BIT_FILT 3
`define SAC_BIT_IND_EN 2
`define SAC_BIT_IND_POL 1
`define SAC_BIT_IND_SEL 0
`define SAC_SRC2_HI 15
`define SAC_SRC2_LO 12
`define SAC_SRC1_HI 11
`define SAC_SRC1_LO 8
`define SAC_SRC_OFF 4'h0
`define SAC_SRC_MAX 4'h6
`define SAC_FRAME_BITS 5'h10
`define SAC_WR_BIT 15
`endif

// >>> verilog/sac_pkg.sv
// Types shared by the alarm block
package sac_pkg;
  typedef struct packed {
    logic [15:0] x_rate;
    logic [15:0] y_rate;
    logic [15:0] z_rate;
    logic [15:0] x_accel;
    logic [15:0] y_accel;
    logic [15:0] z_accel;
  } sac_axes_t;

  typedef struct packed {
    sac_axes_t raw;
    sac_axes_t filt;
  } sac_sample_t;

  typedef enum logic {
    SAC_IDLE = 1'b0,
    SAC_SHIFT = 1'b1
  } sac_spi_st_t;
endpackage : sac_pkg
